// file: hw/qb_port_pkg.sv
// Purpose: constants and types for the quasi-bidirectional port
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: what the block does is listed below
//
// What this block does
// - Every pin owns a latch bit, written directly
// - General port: pull-down plus passive pull-up drive
// - Bus port pull-up only during bus cycles
// - General port strong pull-up pulses only on 0-to-1
// - Source-only reads return the sampled pin level
// - Pin reads low if either side pulls
// - Single-operand read-modify-write uses latch source
// - Logic ops on port read the latch
// - Jump-bit-set-then-clear tests the latch bit
// - Bit operations leave other latch bits alone
package qb_port_pkg;

	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned CLK_PERIOD_NS = 20;
	// Shortest strong pull-up pulse, rounded up to cycles
	localparam int unsigned STRONG_PU_NS = 40;
	localparam int unsigned STRONG_PU_CYCLES = (STRONG_PU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PU_CNT_W = 3;
	localparam logic LATCH_RST_BIT = 1'b1;
	localparam logic OUT_RST_BIT = 1'b0;

	typedef enum logic [3:0] {
		OP_READ_PIN = 4'h0,
		OP_READ_PIN_BIT = 4'h1,
		OP_WRITE = 4'h2,
		OP_LOGICAL_AND = 4'h3,
		OP_LOGICAL_OR = 4'h4,
		OP_LOGICAL_XOR = 4'h5,
		OP_INCREMENT = 4'h6,
		OP_DECREMENT = 4'h7,
		OP_DEC_BRANCH_NZ = 4'h8,
		OP_BIT_COMPLEMENT = 4'h9,
		OP_BIT_SET = 4'ha,
		OP_BIT_CLEAR = 4'hb,
		OP_JUMP_BIT_CLEAR = 4'hc,
		OP_BIT_MOVE = 4'hd
	} op_t;

endpackage

// file: hw/port_drive_if.sv
// Purpose: carries latch state to the pin drivers and drive back
// Assumes: all signals in the clk_i domain
// Notes: drive signals are registered in the driver
interface port_drive_if #(parameter int unsigned WIDTH = 8);
	logic [WIDTH-1:0] latch;
	logic bus_mode;
	logic [WIDTH-1:0] pull_dn;
	logic [WIDTH-1:0] weak_pu;
	logic [WIDTH-1:0] strong_pu;

	modport core (output latch, output bus_mode, input pull_dn, input weak_pu, input strong_pu);
	modport drv (input latch, input bus_mode, output pull_dn, output weak_pu, output strong_pu);
endinterface

// file: hw/pin_driver.sv
// Purpose: per-pin pull-down, passive and strong pull-up control
// Assumes: latch arrives registered from the port core
// Notes: general port strong pull-up timed per pin by a small down counter
module pin_driver
	import qb_port_pkg::*;
#(
	parameter int unsigned WIDTH = PORT_WIDTH,
	parameter bit MUX_BUS_PORT = 1'b0
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Core side
	port_drive_if.drv drv
);

	generate
		if (WIDTH < 1 || STRONG_PU_CYCLES < 1 || STRONG_PU_CYCLES >= (1 << PU_CNT_W))
		begin : g_bad_param
			$error("pin_driver: WIDTH or strong pull-up count out of range");
		end
	endgenerate

	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;
	logic [WIDTH-1:0] pull_dn_q, pull_dn_d;
	logic [WIDTH-1:0] weak_q, weak_d;
	logic [WIDTH-1:0] strong_q, strong_d;

	assign prev_d = drv.latch;
	assign drv.pull_dn = pull_dn_q;
	assign drv.weak_pu = weak_q;
	assign drv.strong_pu = strong_q;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_pin
			logic [PU_CNT_W-1:0] cnt_q, cnt_d;
			always_comb
			begin
				cnt_d = cnt_q;
				if (drv.latch[g] && !prev_q[g])
					cnt_d = PU_CNT_W'(STRONG_PU_CYCLES);
				else if (cnt_q != '0)
					cnt_d = cnt_q - PU_CNT_W'(1);
			end
			// One driver per bit, so each pin owns its slice
			assign pull_dn_d[g] = ~drv.latch[g];
			// Passive pull-up on the general port only; the bus port never has one
			assign weak_d[g] = !MUX_BUS_PORT;
			assign strong_d[g] = MUX_BUS_PORT ? (drv.bus_mode && drv.latch[g]) : (cnt_d != '0);
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cnt_q <= '0;
				else
					cnt_q <= cnt_d;
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prev_q <= {WIDTH{LATCH_RST_BIT}};
			pull_dn_q <= {WIDTH{OUT_RST_BIT}};
			weak_q <= {WIDTH{OUT_RST_BIT}};
			strong_q <= {WIDTH{OUT_RST_BIT}};
		end
		else
		begin
			prev_q <= prev_d;
			pull_dn_q <= pull_dn_d;
			weak_q <= weak_d;
			strong_q <= strong_d;
		end
	end

endmodule

// file: hw/quasi_bidir_port.sv
// Purpose: quasi-bidirectional port latch, pin sampling and operations
// Assumes: core presents one operation per cycle; inputs synchronous
// Notes: ext_level_i is the outside driver, high when it floats
module quasi_bidir_port
	import qb_port_pkg::*;
#(
	parameter int unsigned WIDTH = PORT_WIDTH,
	parameter bit MUX_BUS_PORT = 1'b0
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Core operation request
	input wire logic op_valid_i,
	input wire op_t op_kind_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic bus_mode_i,
	// Core results
	output logic [WIDTH-1:0] rd_data_o,
	output logic rd_bit_o,
	output logic branch_o,
	output logic done_o,
	// Pins
	input wire logic [WIDTH-1:0] ext_level_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_o,
	output logic [WIDTH-1:0] weak_pu_o,
	output logic [WIDTH-1:0] strong_pu_o
);

	generate
		if (WIDTH < 1 || WIDTH > 8)
		begin : g_bad_width
			$error("quasi_bidir_port: WIDTH must be 1 to 8");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// State
	logic [WIDTH-1:0] latch_q, latch_d;
	logic [WIDTH-1:0] rd_data_q, rd_data_d;
	logic rd_bit_q, rd_bit_d;
	logic branch_q, branch_d;
	logic done_q, done_d;
	logic [WIDTH-1:0] pin_out_q;
	logic bus_mode_q, bus_mode_d;
	logic [WIDTH-1:0] pin_level;
	logic [WIDTH-1:0] bit_mask;
	logic latch_bit;

	port_drive_if #(.WIDTH(WIDTH)) drive ();

	pin_driver #(.WIDTH(WIDTH), .MUX_BUS_PORT(MUX_BUS_PORT)) u_drv (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drv(drive.drv)
	);

	assign drive.latch = latch_q;
	assign drive.bus_mode = bus_mode_q;

	////////////////////////////////////////////////////////////////
	// Pin level and bit selection
	assign pin_level = latch_q & ext_level_i;
	assign bit_mask = WIDTH'(1) << bit_sel_i;
	assign latch_bit = |(latch_q & bit_mask);

	////////////////////////////////////////////////////////////////
	// Operation decode
	always_comb
	begin
		latch_d = latch_q;
		rd_data_d = rd_data_q;
		rd_bit_d = rd_bit_q;
		branch_d = 1'b0;
		done_d = op_valid_i;
		bus_mode_d = bus_mode_i;
		if (op_valid_i)
		begin
			case (op_kind_i)
				OP_READ_PIN:
				begin
					rd_data_d = pin_level;
				end
				OP_READ_PIN_BIT:
				begin
					rd_bit_d = |(pin_level & bit_mask);
				end
				OP_WRITE:
				begin
					latch_d = data_i;
				end
				OP_LOGICAL_AND:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q & data_i;
				end
				OP_LOGICAL_OR:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q | data_i;
				end
				OP_LOGICAL_XOR:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q ^ data_i;
				end
				OP_INCREMENT:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q + WIDTH'(1);
				end
				OP_DECREMENT:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q - WIDTH'(1);
				end
				OP_DEC_BRANCH_NZ:
				begin
					rd_data_d = latch_q;
					latch_d = latch_q - WIDTH'(1);
					branch_d = (latch_q != WIDTH'(1));
				end
				OP_BIT_COMPLEMENT:
				begin
					rd_bit_d = latch_bit;
					latch_d = latch_q ^ bit_mask;
				end
				OP_BIT_SET:
				begin
					latch_d = latch_q | bit_mask;
				end
				OP_BIT_CLEAR:
				begin
					latch_d = latch_q & ~bit_mask;
				end
				OP_JUMP_BIT_CLEAR:
				begin
					rd_bit_d = latch_bit;
					branch_d = latch_bit;
					latch_d = latch_q & ~bit_mask;
				end
				OP_BIT_MOVE:
				begin
					latch_d = data_i[0] ? (latch_q | bit_mask) : (latch_q & ~bit_mask);
				end
				default:
				begin
					done_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			latch_q <= {WIDTH{LATCH_RST_BIT}};
			rd_data_q <= {WIDTH{OUT_RST_BIT}};
			rd_bit_q <= OUT_RST_BIT;
			branch_q <= OUT_RST_BIT;
			done_q <= OUT_RST_BIT;
			pin_out_q <= {WIDTH{OUT_RST_BIT}};
			bus_mode_q <= OUT_RST_BIT;
		end
		else
		begin
			latch_q <= latch_d;
			rd_data_q <= rd_data_d;
			rd_bit_q <= rd_bit_d;
			branch_q <= branch_d;
			done_q <= done_d;
			pin_out_q <= {WIDTH{OUT_RST_BIT}};
			bus_mode_q <= bus_mode_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign rd_data_o = rd_data_q;
	assign rd_bit_o = rd_bit_q;
	assign branch_o = branch_q;
	assign done_o = done_q;
	// Pin only ever pulled low by the port itself
	assign pin_o = pin_out_q;
	assign pin_oe_o = drive.pull_dn;
	assign weak_pu_o = drive.weak_pu;
	assign strong_pu_o = drive.strong_pu;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	reset_ones_a: assert property (disable iff (1'b0) rst_i |=> latch_q == {WIDTH{1'b1}})
		else $error("latch not all ones after reset");
	latch_write_a: assert property (op_valid_i && op_kind_i == OP_WRITE |=> latch_q == $past(data_i))
		else $error("byte write did not reach latch");
	pin_read_a: assert property (op_valid_i && op_kind_i == OP_READ_PIN
		|=> rd_data_o == ($past(latch_q) & $past(ext_level_i)))
		else $error("pin read did not return pin level");
	pin_low_a: assert property (op_valid_i && op_kind_i == OP_READ_PIN && ext_level_i != {WIDTH{1'b1}}
		|=> rd_data_o != {WIDTH{1'b1}})
		else $error("external low not seen on pin read");
	inc_latch_a: assert property (op_valid_i && op_kind_i == OP_INCREMENT
		|=> rd_data_o == $past(latch_q) && latch_q == WIDTH'($past(latch_q) + 1))
		else $error("increment not taken from latch");
	logic_latch_a: assert property (op_valid_i && op_kind_i == OP_LOGICAL_AND
		|=> latch_q == ($past(latch_q) & $past(data_i)))
		else $error("logical and not taken from latch");
	jump_latch_a: assert property (op_valid_i && op_kind_i == OP_JUMP_BIT_CLEAR
		|=> branch_o == $past(latch_bit) && done_o)
		else $error("jump bit test not from latch");
	bit_others_a: assert property (op_valid_i && (op_kind_i inside {OP_BIT_SET, OP_BIT_CLEAR,
		OP_BIT_COMPLEMENT, OP_JUMP_BIT_CLEAR, OP_BIT_MOVE})
		|=> ((latch_q ^ $past(latch_q)) & ~$past(bit_mask)) == '0)
		else $error("bit operation disturbed other latch bits");
	pull_down_a: assert property (##1 pin_oe_o == ~$past(latch_q))
		else $error("pull-down does not follow latch");
	// Latch must have held ones a cycle already, else a pulse is still due
	no_rewrite_pu_a: assert property (!MUX_BUS_PORT && strong_pu_o == '0 && latch_q == {WIDTH{1'b1}}
		&& $past(latch_q) == {WIDTH{1'b1}}
		&& op_valid_i && op_kind_i == OP_WRITE && data_i == {WIDTH{1'b1}} |=> ##1 strong_pu_o == '0)
		else $error("strong pull-up on rewrite of one");
	rise_pu_a: assert property (!MUX_BUS_PORT && latch_q == '0 && op_valid_i && op_kind_i == OP_WRITE
		&& data_i == {WIDTH{1'b1}} |-> ##2 strong_pu_o == {WIDTH{1'b1}})
		else $error("no strong pull-up on rising latch");
	mux_open_a: assert property (MUX_BUS_PORT && !bus_mode_q |=> weak_pu_o == '0 && strong_pu_o == '0)
		else $error("bus port pulled up outside bus cycles");

	pin_read_c: cover property (op_valid_i && op_kind_i == OP_READ_PIN && ext_level_i != {WIDTH{1'b1}});
	jump_taken_c: cover property (op_valid_i && op_kind_i == OP_JUMP_BIT_CLEAR && latch_bit);
	strong_pu_c: cover property (strong_pu_o != '0);
	bus_pu_c: cover property (MUX_BUS_PORT && bus_mode_q && strong_pu_o != '0);

endmodule

// file: test/ext_driver_model.sv
// Purpose: model of an outside device wired to the port pins
// Assumes: pins carry a pull-up, so a released pin reads high
// Notes: pulls low only the bits named in pull_low_i
module ext_driver_model
	import qb_port_pkg::*;
(
	// Control from bench
	input wire logic [PORT_WIDTH-1:0] pull_low_i,
	// Pin side
	output logic [PORT_WIDTH-1:0] ext_level_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released bits float up, never hold a stale low
	assign ext_level_o = ~pull_low_i;
endmodule

// file: test/quasi_bidirectional_io_port_test.sv
// Purpose: self-checking bench for the quasi-bidirectional port
// Assumes: general and bus port instances, outside device held by the model
// Notes: latch contents are seen through rmw source values
module quasi_bidirectional_io_port_test
	import qb_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic op_valid = 1'b0;
	op_t op_kind = OP_READ_PIN;
	logic [2:0] bit_sel = 3'h0;
	logic [7:0] data = 8'h00;
	logic [7:0] pull_low = 8'h00;
	logic bus_mode = 1'b0;
	logic [7:0] mux_weak_pu, mux_strong_pu;
	logic [7:0] ext_level;
	logic [7:0] rd_data, pin, pin_oe, weak_pu, strong_pu;
	logic rd_bit, branch, done;
	int n_fail = 0;
	int checks_done = 0;

	always #10 clk_i = ~clk_i;

	quasi_bidir_port quasi_bidir_port_i (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid),
		.op_kind_i(op_kind), .bit_sel_i(bit_sel), .data_i(data), .bus_mode_i(bus_mode),
		.rd_data_o(rd_data), .rd_bit_o(rd_bit), .branch_o(branch), .done_o(done),
		.ext_level_i(ext_level), .pin_o(pin), .pin_oe_o(pin_oe), .weak_pu_o(weak_pu),
		.strong_pu_o(strong_pu));

	// Bus port twin, fed the same operations
	quasi_bidir_port #(.WIDTH(8), .MUX_BUS_PORT(1'b1)) quasi_bidir_port_mux_i (.clk_i(clk_i), .rst_i(rst_i),
		.op_valid_i(op_valid), .op_kind_i(op_kind), .bit_sel_i(bit_sel), .data_i(data), .bus_mode_i(bus_mode),
		.rd_data_o(), .rd_bit_o(), .branch_o(), .done_o(), .ext_level_i(ext_level), .pin_o(), .pin_oe_o(),
		.weak_pu_o(mux_weak_pu), .strong_pu_o(mux_strong_pu));

	ext_driver_model ext_driver_model_i (.pull_low_i(pull_low), .ext_level_o(ext_level));

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One operation; returns just after the edge that took it
	task automatic op(input op_t k, input logic [2:0] s, input logic [7:0] d);
		@(posedge clk_i);
		op_valid <= 1'b1;
		op_kind <= k;
		bit_sel <= s;
		data <= d;
		@(posedge clk_i);
		op_valid <= 1'b0;
		#1;
		chk({7'h0, done}, 8'h01);
	endtask

	task automatic pulls(input logic [7:0] m);
		@(posedge clk_i);
		pull_low <= m;
	endtask

	// Strong pull-up for two cycles after the op, then off
	task automatic pulse(input logic [7:0] exp);
		@(posedge clk_i);
		#1;
		chk(strong_pu, exp);
		@(posedge clk_i);
		#1;
		chk(strong_pu, exp);
		@(posedge clk_i);
		#1;
		chk(strong_pu, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		op(OP_READ_PIN, 3'h0, 8'h00);
		chk(rd_data, 8'hff);
		chk(weak_pu, 8'hff);
		chk(pin_oe, 8'h00);
		chk(pin, 8'h00);
		@(posedge clk_i);
		op_valid <= 1'b1;
		op_kind <= op_t'(4'he);
		@(posedge clk_i);
		op_valid <= 1'b0;
		#1;
		chk({7'h0, done}, 8'h00);
	endtask

	task automatic t_strong();
		op(OP_WRITE, 3'h0, 8'h00);
		@(posedge clk_i);
		#1;
		chk(pin_oe, 8'hff);
		op(OP_WRITE, 3'h0, 8'h0f);
		pulse(8'h0f);
		op(OP_WRITE, 3'h0, 8'h3f);
		pulse(8'h30);
		op(OP_WRITE, 3'h0, 8'h3f);
		pulse(8'h00);
		op(OP_WRITE, 3'h0, 8'hff);
		pulse(8'hc0);
		op(OP_WRITE, 3'h0, 8'h00);
		op(OP_WRITE, 3'h0, 8'hff);
		pulse(8'hff);
		op(OP_WRITE, 3'h0, 8'hff);
		pulse(8'h00);
	endtask

	task automatic t_pin();
		pulls(8'h5a);
		op(OP_READ_PIN, 3'h0, 8'h00);
		chk(rd_data, 8'ha5);
		op(OP_READ_PIN_BIT, 3'h1, 8'h00);
		chk({7'h0, rd_bit}, 8'h00);
		op(OP_READ_PIN_BIT, 3'h0, 8'h00);
		chk({7'h0, rd_bit}, 8'h01);
	endtask

	// Outside device still pulls 5a low, so a pin source would differ
	task automatic t_rmw();
		op(OP_LOGICAL_AND, 3'h0, 8'hf0);
		chk(rd_data, 8'hff);
		op(OP_LOGICAL_OR, 3'h0, 8'h0f);
		chk(rd_data, 8'hf0);
		op(OP_LOGICAL_XOR, 3'h0, 8'h81);
		chk(rd_data, 8'hff);
		op(OP_INCREMENT, 3'h0, 8'h00);
		chk(rd_data, 8'h7e);
		op(OP_DECREMENT, 3'h0, 8'h00);
		chk(rd_data, 8'h7f);
		op(OP_BIT_COMPLEMENT, 3'h1, 8'h00);
		chk({7'h0, rd_bit}, 8'h01);
		op(OP_JUMP_BIT_CLEAR, 3'h3, 8'h00);
		chk({7'h0, branch}, 8'h01);
		op(OP_JUMP_BIT_CLEAR, 3'h3, 8'h00);
		chk({7'h0, branch}, 8'h00);
		op(OP_BIT_SET, 3'h7, 8'h00);
		op(OP_BIT_CLEAR, 3'h2, 8'h00);
		op(OP_BIT_MOVE, 3'h0, 8'h01);
		pulls(8'h00);
		op(OP_READ_PIN, 3'h0, 8'h00);
		chk(rd_data, 8'hf1);
	endtask

	task automatic t_decrement_branch_nonzero();
		op(OP_WRITE, 3'h0, 8'h01);
		op(OP_DEC_BRANCH_NZ, 3'h0, 8'h00);
		chk({7'h0, branch}, 8'h00);
		chk(rd_data, 8'h01);
		op(OP_DEC_BRANCH_NZ, 3'h0, 8'h00);
		chk({7'h0, branch}, 8'h01);
		op(OP_READ_PIN, 3'h0, 8'h00);
		chk(rd_data, 8'hff);
	endtask

	// Bus port: open drain until bus cycles run
	task automatic t_mux();
		chk(mux_weak_pu, 8'h00);
		chk(mux_strong_pu, 8'h00);
		@(posedge clk_i);
		bus_mode <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk(mux_strong_pu, 8'hff);
		chk(mux_weak_pu, 8'h00);
		chk(strong_pu, 8'h00);
		@(posedge clk_i);
		bus_mode <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(mux_strong_pu, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_strong();
		t_pin();
		t_rmw();
		t_decrement_branch_nonzero();
		t_mux();
		end_sim();
	end

	// Cuts a hang short
	initial
	begin
		repeat (5000) @(posedge clk_i);
		n_fail++;
		end_sim();
	end
endmodule
